// ==== rtl/gpes_edge_detect.sv ====
// Per-bit transition detector with selectable edge polarity
`timescale 1ns/1ps
module gpes_edge_detect #(
    parameter int WIDTH = 7
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] level,
    input wire logic [WIDTH-1:0] riseSel,
    output logic [WIDTH-1:0] edgeSeen
);

    logic [WIDTH-1:0] prevLevel_reg;
    logic primed_reg;
    logic [WIDTH-1:0] risen;
    logic [WIDTH-1:0] fallen;

    // History of the inputs; the primed flag hides the first cycle after reset
    // so a pin already high at release does not look like a rising edge
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            prevLevel_reg <= '0;
            primed_reg <= 1'b0;
        end
        else
        begin
            prevLevel_reg <= level;
            primed_reg <= 1'b1;
        end
    end

    // Select the wanted edge per bit
    assign risen = level & ~prevLevel_reg;
    assign fallen = ~level & prevLevel_reg;
    assign edgeSeen = primed_reg ? ((risen & riseSel) | (fallen & ~riseSel)) : '0;

endmodule : gpes_edge_detect

// ==== rtl/gpes_pkg.sv ====
// Shared constants and carrier types for the pin and time event status latch
package gpes_pkg;

    // Register port geometry
    localparam int ADDR_WIDTH = 5;
    localparam int DATA_WIDTH = 16;

    // Register offsets on the serial peripheral port map
    localparam logic [ADDR_WIDTH-1:0] PIN_EVENT_STATUS_OFFS = 5'h03;
    localparam logic [ADDR_WIDTH-1:0] TIME_EVENT_STATUS_OFFS = 5'h04;

    // Reset values
    localparam logic [DATA_WIDTH-1:0] PIN_EVENT_STATUS_RESET = 16'h0000;
    localparam logic [DATA_WIDTH-1:0] TIME_EVENT_STATUS_RESET = 16'h0000;

    // Pin event status field layout
    localparam int PIN_COUNT = 7;
    localparam int PIN_LOWER_COUNT = 3;
    localparam int PIN_LEVEL_LSB = 0;
    localparam int PIN_LATCH_LSB = 8;

    // Time event status field positions
    localparam int TE_GENERAL_SUMMARY = 15;
    localparam int TE_TIME_SUMMARY = 14;
    localparam int TE_FIFO3_OVERFLOW = 13;
    localparam int TE_FIFO3_NONEMPTY = 12;
    localparam int TE_FIFO2_OVERFLOW = 11;
    localparam int TE_FIFO2_NONEMPTY = 10;
    localparam int TE_FIFO1_OVERFLOW = 9;
    localparam int TE_FIFO1_NONEMPTY = 8;
    localparam int TE_GEN2_FIFO_FREED = 6;
    localparam int TE_GEN2_SEQUENCE_DONE = 5;
    localparam int TE_GEN2_EVENT_DONE = 4;
    localparam int TE_GEN1_FIFO_FREED = 3;
    localparam int TE_GEN1_SEQUENCE_DONE = 2;
    localparam int TE_GEN1_EVENT_DONE = 1;
    localparam int TE_TIME_ADJUST_DONE = 0;

    // Bits of the time event register that can latch at all
    localparam logic [DATA_WIDTH-1:0] TE_LATCH_MASK = 16'h3F7F;

    // Count of level sources watched for a transition on the time side
    localparam int TE_LEVEL_COUNT = 5;

    // Register read request from the serial port engine
    typedef struct packed {
        logic read;
        logic [ADDR_WIDTH-1:0] addr;
    } gpes_read_req_type;

    // Time engine event sources
    typedef struct packed {
        logic [2:0] stampOverflow;
        logic [2:0] stampNonempty;
        logic gen2FifoFull;
        logic gen1FifoFull;
        logic gen2SequenceDone;
        logic gen1SequenceDone;
        logic gen2EventDone;
        logic gen2EventMarked;
        logic gen1EventDone;
        logic gen1EventMarked;
        logic timeAdjustDone;
    } gpes_time_events_type;

endpackage : gpes_pkg

// ==== rtl/gpes_status_latch.sv ====
// Pin event status and time event interrupt status registers with clear on read
//
// Functional notes
// [RQ1] Pins 4-7 latch on upper group edge
// [RQ2] Pins 1-3 latch on lower group edge
// [RQ3] Latched bits hold until software reads them
// [RQ4] Low status bits show live pin levels
// [RQ5] Bit 15 shows general interrupt summary
// [RQ6] Bit 14 ORs enabled latched time events
// [RQ7] Latch stamp FIFO overflows in bits 13,11,9
// [RQ8] Latch stamp FIFO empty-to-nonempty in 12,10,8
// [RQ9] Latch generator FIFO full-to-not-full, bits 6,3
// [RQ10] Latch generator sequence done, bits 5,2
// [RQ11] Latch marked generator event done, bits 4,1
// [RQ12] Latch time adjustment done in bit 0
// [RQ13] Drive interrupt out when enabled event latched
// [RQ14] Edge select: zero falling, one rising
// [RQ15] Per-bit enable masks events from summary
// [RQ16] Event during clearing read stays set
// [RQ17] Reserved bits read zero, latches reset zero
`timescale 1ns/1ps
module gpes_status_latch #(
    parameter int PIN_COUNT = gpes_pkg::PIN_COUNT
) (
    input wire logic clk,
    input wire logic resetn,
    input wire gpes_pkg::gpes_read_req_type readReq,
    output logic readHit,
    output logic [gpes_pkg::DATA_WIDTH-1:0] readData,
    input wire logic [PIN_COUNT-1:0] pinLevel,
    input wire logic upperGroupEdgeSelect,
    input wire logic lowerGroupEdgeSelect,
    input wire logic [gpes_pkg::DATA_WIDTH-1:0] timeEventEnable,
    input wire logic generalInterruptSummary,
    input wire gpes_pkg::gpes_time_events_type timeEvents,
    output logic timeEventIrq,
    output logic timeEventSummary
);

    localparam int DW = gpes_pkg::DATA_WIDTH;
    localparam int LOWER = gpes_pkg::PIN_LOWER_COUNT;

    // Address decode helper, used for both registers
    function automatic logic addrIs(
        input gpes_pkg::gpes_read_req_type req,
        input logic [gpes_pkg::ADDR_WIDTH-1:0] offs
    );
        addrIs = req.read && (req.addr == offs);
    endfunction : addrIs

    // Read strobes for the two registers
    wire readPin = addrIs(readReq, gpes_pkg::PIN_EVENT_STATUS_OFFS);
    wire readTime = addrIs(readReq, gpes_pkg::TIME_EVENT_STATUS_OFFS);

    logic [PIN_COUNT-1:0] pinRiseSel;
    logic [PIN_COUNT-1:0] pinEdge;
    logic [PIN_COUNT-1:0] pinLatched;
    logic [PIN_COUNT-1:0] pinClear;

    // Edge polarity per pin from its group select
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++)
        begin : gPinSel
            if (gi < LOWER)
            begin : gLower
                assign pinRiseSel[gi] = lowerGroupEdgeSelect; // [RQ2] [RQ14]
            end
            else
            begin : gUpper
                assign pinRiseSel[gi] = upperGroupEdgeSelect; // [RQ1] [RQ14]
            end
        end
    endgenerate

    // Transition detection on the pins
    gpes_edge_detect #(
        .WIDTH(PIN_COUNT)
    ) uPinEdge (
        .clk(clk),
        .resetn(resetn),
        .level(pinLevel),
        .riseSel(pinRiseSel),
        .edgeSeen(pinEdge)
    );

    // Clearing a read only drops bits that were reported in that read;
    // a new edge in the same cycle is set again by the sticky logic
    assign pinClear = readPin ? pinLatched : '0; // [RQ3]

    gpes_sticky_bits #(
        .WIDTH(PIN_COUNT),
        .RESET_VALUE('0)
    ) uPinSticky (
        .clk(clk),
        .resetn(resetn),
        .setBits(pinEdge), // [RQ1] [RQ2] [RQ16]
        .clearBits(pinClear),
        .flags(pinLatched) // [RQ17]
    );

    // Readback image: reserved bits 15 and 7 are zero
    logic [DW-1:0] pinImage;
    always_comb
    begin
        pinImage = '0; // [RQ17]
        pinImage[gpes_pkg::PIN_LATCH_LSB +: PIN_COUNT] = pinLatched; // [RQ3]
        pinImage[gpes_pkg::PIN_LEVEL_LSB +: PIN_COUNT] = pinLevel; // [RQ4]
    end

    // Levels whose rising edge is an event: nonempty flags and not-full
    localparam int TL = gpes_pkg::TE_LEVEL_COUNT;
    logic [TL-1:0] teLevel;
    logic [TL-1:0] teRise;

    assign teLevel = {timeEvents.stampNonempty, ~timeEvents.gen2FifoFull, ~timeEvents.gen1FifoFull};

    gpes_edge_detect #(
        .WIDTH(TL)
    ) uTimeEdge (
        .clk(clk),
        .resetn(resetn),
        .level(teLevel),
        .riseSel({TL{1'b1}}),
        .edgeSeen(teRise)
    );

    // Named event wires
    wire [2:0] stampNonemptyRise = teRise[TL-1 -: 3]; // [RQ8]
    wire gen2Freed = teRise[1]; // [RQ9]
    wire gen1Freed = teRise[0]; // [RQ9]
    // Only commands marked for status latching report completion
    wire gen2EventLatch = timeEvents.gen2EventDone & timeEvents.gen2EventMarked; // [RQ11]
    wire gen1EventLatch = timeEvents.gen1EventDone & timeEvents.gen1EventMarked; // [RQ11]

    // Gather sources into register positions
    logic [DW-1:0] teSet;
    always_comb
    begin
        teSet = '0;
        teSet[gpes_pkg::TE_FIFO3_OVERFLOW] = timeEvents.stampOverflow[2]; // [RQ7]
        teSet[gpes_pkg::TE_FIFO2_OVERFLOW] = timeEvents.stampOverflow[1]; // [RQ7]
        teSet[gpes_pkg::TE_FIFO1_OVERFLOW] = timeEvents.stampOverflow[0]; // [RQ7]
        teSet[gpes_pkg::TE_FIFO3_NONEMPTY] = stampNonemptyRise[2]; // [RQ8]
        teSet[gpes_pkg::TE_FIFO2_NONEMPTY] = stampNonemptyRise[1]; // [RQ8]
        teSet[gpes_pkg::TE_FIFO1_NONEMPTY] = stampNonemptyRise[0]; // [RQ8]
        teSet[gpes_pkg::TE_GEN2_FIFO_FREED] = gen2Freed; // [RQ9]
        teSet[gpes_pkg::TE_GEN1_FIFO_FREED] = gen1Freed; // [RQ9]
        teSet[gpes_pkg::TE_GEN2_SEQUENCE_DONE] = timeEvents.gen2SequenceDone; // [RQ10]
        teSet[gpes_pkg::TE_GEN1_SEQUENCE_DONE] = timeEvents.gen1SequenceDone; // [RQ10]
        teSet[gpes_pkg::TE_GEN2_EVENT_DONE] = gen2EventLatch; // [RQ11]
        teSet[gpes_pkg::TE_GEN1_EVENT_DONE] = gen1EventLatch; // [RQ11]
        teSet[gpes_pkg::TE_TIME_ADJUST_DONE] = timeEvents.timeAdjustDone; // [RQ12]
        teSet = teSet & gpes_pkg::TE_LATCH_MASK; // [RQ17]
    end

    logic [DW-1:0] teLatched;
    wire [DW-1:0] teClear = readTime ? teLatched : '0; // [RQ3]

    gpes_sticky_bits #(
        .WIDTH(DW),
        .RESET_VALUE(gpes_pkg::TIME_EVENT_STATUS_RESET)
    ) uTimeSticky (
        .clk(clk),
        .resetn(resetn),
        .setBits(teSet), // [RQ16]
        .clearBits(teClear),
        .flags(teLatched) // [RQ17]
    );

    // Summary of enabled latched events; reserved and summary bits excluded
    wire timeSummary = |(teLatched & timeEventEnable & gpes_pkg::TE_LATCH_MASK); // [RQ6] [RQ15]

    // Readback image: bit 7 always zero since it never latches
    logic [DW-1:0] teImage;
    always_comb
    begin
        teImage = teLatched & gpes_pkg::TE_LATCH_MASK; // [RQ17]
        teImage[gpes_pkg::TE_GENERAL_SUMMARY] = generalInterruptSummary; // [RQ5]
        teImage[gpes_pkg::TE_TIME_SUMMARY] = timeSummary; // [RQ6]
    end

    // Selected image; other offsets belong to neighbouring registers
    wire hitNow = readPin | readTime;
    wire [DW-1:0] readImage = readPin ? pinImage : (readTime ? teImage : '0);

    logic [DW-1:0] readData_reg;
    logic readHit_reg;
    logic irq_reg;

    // Data is captured in the read cycle, the same edge that clears the latches
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            readData_reg <= gpes_pkg::PIN_EVENT_STATUS_RESET;
            readHit_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            readHit_reg <= hitNow;
            if (hitNow)
                readData_reg <= readImage; // [RQ3]
            irq_reg <= timeSummary; // [RQ13]
        end
    end

    // Pin routing of the interrupt is done by the pin function logic outside
    assign readData = readData_reg;
    assign readHit = readHit_reg;
    assign timeEventIrq = irq_reg; // [RQ13]
    assign timeEventSummary = timeSummary; // [RQ6]

endmodule : gpes_status_latch

// ==== rtl/gpes_sticky_bits.sv ====
// Set-dominant sticky flags cleared by a clear mask
`timescale 1ns/1ps
module gpes_sticky_bits #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] setBits,
    input wire logic [WIDTH-1:0] clearBits,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // Set wins over clear so an event racing the read is kept
    assign flags_next = (flags_reg & ~clearBits) | setBits;

    always_ff @(posedge clk)
    begin
        if (!resetn)
            flags_reg <= RESET_VALUE;
        else
            flags_reg <= flags_next;
    end

    assign flags = flags_reg;

endmodule : gpes_sticky_bits

// ==== tb/gpes_status_latch_checker.sv ====
// Port-level assertion checker for the pin and time event status latch
`timescale 1ns/1ps
module gpes_status_latch_checker #(
    parameter int PIN_COUNT = gpes_pkg::PIN_COUNT
) (
    input wire logic clk,
    input wire logic resetn,
    input wire gpes_pkg::gpes_read_req_type readReq,
    input wire logic readHit,
    input wire logic [gpes_pkg::DATA_WIDTH-1:0] readData,
    input wire logic [PIN_COUNT-1:0] pinLevel,
    input wire logic upperGroupEdgeSelect,
    input wire logic lowerGroupEdgeSelect,
    input wire logic [gpes_pkg::DATA_WIDTH-1:0] timeEventEnable,
    input wire logic generalInterruptSummary,
    input wire gpes_pkg::gpes_time_events_type timeEvents,
    input wire logic timeEventIrq,
    input wire logic timeEventSummary
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Read strobes per mapped register
    wire logic rdPin = readReq.read && (readReq.addr == gpes_pkg::PIN_EVENT_STATUS_OFFS);
    wire logic rdTime = readReq.read && (readReq.addr == gpes_pkg::TIME_EVENT_STATUS_OFFS);
    wire logic rdMap = rdPin || rdTime;

    a_read_answer: assert property (rdMap |=> readHit)
        else $error("mapped read got no answer");
    a_unmapped_quiet: assert property (readHit |-> $past(rdMap))
        else $error("answer without a mapped read");
    a_live_levels: assert property (readHit && $past(rdPin) |-> readData[6:0] == $past(pinLevel))
        else $error("live pin levels wrong");
    a_pin_reserved: assert property (readHit && $past(rdPin) |-> !readData[15] && !readData[7])
        else $error("pin register reserved bit set");
    a_general_bit: assert property (readHit && $past(rdTime) |->
        readData[15] == $past(generalInterruptSummary) && !readData[7])
        else $error("general summary bit wrong");
    a_masked_quiet: assert property (timeEventEnable == 16'h0000 |-> !timeEventSummary)
        else $error("summary high with all enables off");
    a_adjust_sets: assert property (timeEvents.timeAdjustDone && timeEventEnable[0] |=>
        timeEventSummary || !timeEventEnable[0])
        else $error("adjust done did not reach summary");
    a_latch_holds: assert property (timeEventSummary && !readReq.read |=>
        timeEventSummary || $changed(timeEventEnable))
        else $error("latched event lost without a read");
    a_irq_follows: assert property ($rose(timeEventSummary) |=> timeEventIrq)
        else $error("interrupt output did not follow summary");
endmodule : gpes_status_latch_checker

bind gpes_status_latch gpes_status_latch_checker #(.PIN_COUNT(PIN_COUNT)) i_checker (.clk(clk),
    .resetn(resetn), .readReq(readReq), .readHit(readHit), .readData(readData), .pinLevel(pinLevel),
    .upperGroupEdgeSelect(upperGroupEdgeSelect), .lowerGroupEdgeSelect(lowerGroupEdgeSelect),
    .timeEventEnable(timeEventEnable), .generalInterruptSummary(generalInterruptSummary),
    .timeEvents(timeEvents), .timeEventIrq(timeEventIrq), .timeEventSummary(timeEventSummary));

// ==== tb/gpes_status_latch_tb_top.sv ====
// Self-checking testbench for the pin and time event status latch
`timescale 1ns/1ps
module gpes_status_latch_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    gpes_pkg::gpes_read_req_type req = '0;
    logic hit;
    logic [15:0] dat;
    logic [6:0] pin = 7'h00;
    logic upSel = 1'b0;
    logic loSel = 1'b0;
    logic [15:0] en = 16'h0000;
    logic gis = 1'b0;
    logic [14:0] base = 15'h0180; // Generator FIFOs idle full
    gpes_pkg::gpes_time_events_type tev;
    logic irq;
    logic summ;
    int err_count = 0;
    int cmp_count = 0;
    // One source per entry, last one is an unmarked event completion
    logic [14:0] stim [14] = '{15'h4180, 15'h2180, 15'h1180, 15'h0980, 15'h0580, 15'h0380, 15'h0080,
        15'h0100, 15'h01C0, 15'h01A0, 15'h0198, 15'h0186, 15'h0181, 15'h0190};
    logic [15:0] expv [14] = '{16'h2000, 16'h0800, 16'h0200, 16'h1000, 16'h0400, 16'h0100, 16'h0040,
        16'h0008, 16'h0020, 16'h0004, 16'h0010, 16'h0002, 16'h0001, 16'h0000};

    // 200 MHz clock
    always #2.5 clk = ~clk;

    gpes_status_latch i_dut (.clk(clk), .resetn(resetn), .readReq(req), .readHit(hit), .readData(dat),
        .pinLevel(pin), .upperGroupEdgeSelect(upSel), .lowerGroupEdgeSelect(loSel), .timeEventEnable(en),
        .generalInterruptSummary(gis), .timeEvents(tev), .timeEventIrq(irq), .timeEventSummary(summ));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One read, answer seen one cycle later; idle cycle after so strobes never stack
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        req.read = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.read = 1'b0;
        // Only the two mapped offsets answer
        check({15'h0000, hit}, {15'h0000, (a == gpes_pkg::PIN_EVENT_STATUS_OFFS) ||
            (a == gpes_pkg::TIME_EVENT_STATUS_OFFS)});
        check(dat, exp);
        @(negedge clk);
    endtask : rd

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // Upper group on rising, lower group on falling edges
    task automatic pin_edges;
        upSel = 1'b1;
        pin = 7'h7F;
        repeat (2) @(negedge clk);
        rd(5'h03, 16'h787F);
        pin = 7'h00;
        repeat (2) @(negedge clk);
        rd(5'h03, 16'h0700);
        rd(5'h03, 16'h0000);
        rd(5'h05, 16'h0000);
        // Swapped selects: lower group on rising, upper group on falling
        upSel = 1'b0;
        loSel = 1'b1;
        pin = 7'h7F;
        repeat (2) @(negedge clk);
        rd(5'h03, 16'h077F);
        pin = 7'h00;
        repeat (2) @(negedge clk);
        rd(5'h03, 16'h7800);
        loSel = 1'b0;
    endtask : pin_edges

    // Each time source alone, its enable raised so the summary and interrupt follow
    task automatic time_sources;
        for (int k = 0; k < 14; k++)
        begin
            en = expv[k];
            tev = stim[k];
            @(negedge clk);
            tev = base;
            check({15'h0000, summ}, {15'h0000, expv[k] != 16'h0000});
            @(negedge clk);
            check({15'h0000, irq}, {15'h0000, expv[k] != 16'h0000});
            rd(5'h04, expv[k] | (expv[k] != 16'h0000 ? 16'h4000 : 16'h0000));
            check({15'h0000, summ}, 16'h0000);
        end
        en = 16'h0000;
    endtask : time_sources

    // Adjust bit already set, new pulse in the clearing read's cycle must survive
    task automatic read_collision;
        gis = 1'b1;
        tev = 15'h0181;
        @(negedge clk);
        req.read = 1'b1;
        req.addr = 5'h04;
        @(negedge clk);
        tev = base;
        req.read = 1'b0;
        check(dat, 16'h8001);
        @(negedge clk);
        rd(5'h04, 16'h8001);
        rd(5'h04, 16'h8000);
    endtask : read_collision

    initial
    begin
        tev = base;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        rd(5'h03, 16'h0000);
        rd(5'h04, 16'h0000);
        pin_edges();
        time_sources();
        read_collision();
        test_done();
    end

    // Watchdog well past the expected run length
    initial
    begin
        #20000;
        err_count++;
        test_done();
    end
endmodule : gpes_status_latch_tb_top
